/* File: bcc_consts.svh */
// Offsets, field positions, reset values and timing counts for the charger control block
//==============================================================================
// Summary of operation
// - Below threshold charge at tenth current
// - Target and current from charge control
// - Start needs input, enable, precharge range
// - Stop at target minus margin, low current
// - Precharge expiry 40 to 70 minutes
// - Fast charge expiry 6 to 12 hours
// - Timer holds below one fifth current
// - Expiry enters safe mode, tiny current
// - Interrupt when leaving safe mode
// - Safe mode shown in status bit
// - Input or enable toggle exits safe
// - Indicator source selects manual or charger
// - Manual pattern: float, slow, fast, low
// - Mode bit selects indicator type A/B
// - Type A indicator patterns
// - Type B indicator patterns
// - Presence from comparator, interrupt on change
// - Presence status, detection enable bit
// - Detection pulse every sixteen seconds
// - Level one gives minimum current
// - Level three shutdown when enabled
//==============================================================================
`ifndef BCC_CONSTS_SVH
`define BCC_CONSTS_SVH

// Register indexes; byte address is four times the index
`define BCC_IDX_STATUS     8'h01
`define BCC_IDX_LED_DET    8'h32
`define BCC_IDX_CHG_CTRL   8'h33
`define BCC_IDX_TMR_CFG    8'h34
`define BCC_IDX_IRQ_EN     8'h43
`define BCC_IDX_SHDN       8'h8f

// Field positions
`define BCC_ST_DIE_OT      7
`define BCC_ST_BAT_PRES    5
`define BCC_ST_SAFE        3
`define BCC_DET_EN         6
`define BCC_LED_SRC        3
`define BCC_CHG_EN         7
`define BCC_LED_TYPE       4
`define BCC_OT_IRQ_EN      7
`define BCC_SHDN_EN        2

// Reset values
`define BCC_RST_LED_DET    8'h40
`define BCC_RST_CHG_CTRL   8'hc8
`define BCC_RST_TMR_CFG    8'h41
`define BCC_RST_IRQ_EN     8'h00
`define BCC_RST_SHDN       8'h00

// Timing
`define BCC_CLK_HZ         10000000
`define BCC_TICK_HZ        16
`define BCC_DET_PERIOD_S   16
`define BCC_PRE_MIN_BASE   40
`define BCC_PRE_MIN_STEP   10
`define BCC_FAST_HR_BASE   6
`define BCC_FAST_HR_STEP   2
`define BCC_SEC_PER_MIN    60
`define BCC_SEC_PER_HR     3600

`endif

/* File: bcc_pkg.sv */
// Types shared by the charger control block
package bcc_pkg;
	// Charger sequencing states
	typedef enum logic [2:0] {
		CS_IDLE,
		CS_PRE,
		CS_FAST,
		CS_SAFE,
		CS_DONE
	} bcc_state_t;

	// Current request handed to the analog regulator
	typedef enum logic [2:0] {
		CM_OFF,
		CM_PRE_TENTH,
		CM_PROGRAMMED,
		CM_SAFE_TINY,
		CM_MINIMUM
	} bcc_cur_mode_t;
endpackage

/* File: bcc_charger_ctrl.sv */
// Charger control: sequencing, expiry timers, indicator pin, presence and die thermal
`timescale 1ns/1ps
`include "bcc_consts.svh"

module bcc_charger_ctrl import bcc_pkg::*; #(
	parameter int TICK_CYCLES = `BCC_CLK_HZ / `BCC_TICK_HZ
) (
	// Clock, reset, enable
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        ce,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [9:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Analog comparator results
	input  wire logic        input_present,
	input  wire logic        input_overvoltage,
	input  wire logic        above_precharge_threshold,
	input  wire logic        above_term_voltage,
	input  wire logic        current_below_tenth,
	input  wire logic        current_below_fifth,
	input  wire logic        battery_sense_cmp,
	input  wire logic        die_warn_level1,
	input  wire logic        die_warn_level2,
	input  wire logic        die_warn_level3,
	// Regulator control
	output bcc_cur_mode_t    charge_current_mode,
	output logic      [1:0]  charge_target_voltage,
	output logic      [3:0]  charge_current_setting,
	output logic             battery_detect_pulse,
	output logic             shutdown_req,
	// Indicator pin, open drain
	output logic             charge_indicator_pin_out,
	output logic             charge_indicator_pin_oe,
	// Interrupt requests, one-cycle pulses
	output logic             safe_exit_irq,
	output logic             battery_change_irq,
	output logic             die_overtemp_irq
);

	//==========================================================================
	// Helpers
	//==========================================================================
	// Expiry limit in seconds for the phase that is running
	function automatic logic [15:0] limit_sec(input logic fast, input logic [1:0] sel);
		if (fast)
			limit_sec = 16'((`BCC_FAST_HR_BASE + `BCC_FAST_HR_STEP * sel) * `BCC_SEC_PER_HR);
		else
			limit_sec = 16'((`BCC_PRE_MIN_BASE + `BCC_PRE_MIN_STEP * sel) * `BCC_SEC_PER_MIN);
	endfunction

	// Low phase of a 25% duty blink; rate 0..3 = 0.5, 1, 2, 4 Hz
	function automatic logic blink_low(input logic [1:0] rate, input logic [4:0] ph);
		case (rate)
			2'b00:   blink_low = (ph[4:3] == 2'b00);
			2'b01:   blink_low = (ph[3:2] == 2'b00);
			2'b10:   blink_low = (ph[2:1] == 2'b00);
			default: blink_low = (ph[1:0] == 2'b00);
		endcase
	endfunction

	//==========================================================================
	// Registers
	//==========================================================================
	logic [7:0]  reg_led_det;
	logic [7:0]  reg_chg_ctrl;
	logic [7:0]  reg_tmr_cfg;
	logic [7:0]  reg_irq_en;
	logic [7:0]  reg_shdn;
	logic [7:0]  status_byte;
	logic [7:0]  idx;
	logic        wr_en;
	logic        die_ot;
	logic        bat_present;
	bcc_state_t  state;
	bcc_state_t  next_state;

	assign idx   = paddr[9:2];
	assign wr_en = ce && psel && penable && pready && pwrite;

	// Status: die over-temperature, presence, safe mode
	always_comb begin
		status_byte = 8'h00;
		status_byte[`BCC_ST_DIE_OT]   = die_ot;
		status_byte[`BCC_ST_BAT_PRES] = bat_present;
		status_byte[`BCC_ST_SAFE]     = (state == CS_SAFE);
	end

	// Access phase lasts one cycle while ce is high; read data is captured at setup
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (ce) begin
			pready <= psel && !penable && !pready;
			if (psel && !penable) begin
				pslverr <= 1'b0;
				case (idx)
					`BCC_IDX_STATUS:   prdata <= {24'h00_0000, status_byte};
					`BCC_IDX_LED_DET:  prdata <= {24'h00_0000, reg_led_det};
					`BCC_IDX_CHG_CTRL: prdata <= {24'h00_0000, reg_chg_ctrl};
					`BCC_IDX_TMR_CFG:  prdata <= {24'h00_0000, reg_tmr_cfg};
					`BCC_IDX_IRQ_EN:   prdata <= {24'h00_0000, reg_irq_en};
					`BCC_IDX_SHDN:     prdata <= {24'h00_0000, reg_shdn};
					default: begin
						prdata  <= 32'h0000_0000;
						pslverr <= 1'b1;
					end
				endcase
			end
		end
	end

	// Writable registers; unused bits read back zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			reg_led_det  <= `BCC_RST_LED_DET;
			reg_chg_ctrl <= `BCC_RST_CHG_CTRL;
			reg_tmr_cfg  <= `BCC_RST_TMR_CFG;
			reg_irq_en   <= `BCC_RST_IRQ_EN;
			reg_shdn     <= `BCC_RST_SHDN;
		end else if (wr_en) begin
			case (idx)
				`BCC_IDX_LED_DET:  reg_led_det  <= pwdata[7:0] & 8'h78;
				`BCC_IDX_CHG_CTRL: reg_chg_ctrl <= pwdata[7:0] & 8'hef;
				`BCC_IDX_TMR_CFG:  reg_tmr_cfg  <= pwdata[7:0] & 8'hd3;
				`BCC_IDX_IRQ_EN:   reg_irq_en   <= pwdata[7:0] & 8'h80;
				`BCC_IDX_SHDN:     reg_shdn     <= pwdata[7:0] & 8'h04;
				default: ;
			endcase
		end
	end

	//==========================================================================
	// Time base: 1/16 s ticks, blink phase, seconds
	//==========================================================================
	logic [19:0] tick_cnt;
	logic [4:0]  phase;
	logic        tick;
	logic        sec_tick;

	assign tick     = (tick_cnt == 20'(TICK_CYCLES - 1));
	assign sec_tick = tick && (phase[3:0] == 4'hf);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_cnt <= 20'h0_0000;
			phase    <= 5'h00;
		end else if (ce) begin
			tick_cnt <= tick ? 20'h0_0000 : tick_cnt + 20'h0_0001;
			if (tick)
				phase <= phase + 5'h01;
		end
	end

	//==========================================================================
	// Charge sequencing
	//==========================================================================
	logic        chg_en;
	logic        supply_ok;
	logic        charging;
	logic        expired;
	logic        term_ok;
	logic [15:0] tmr_sec;

	assign chg_en    = reg_chg_ctrl[`BCC_CHG_EN];
	assign supply_ok = input_present && chg_en;
	assign charging  = (state == CS_PRE) || (state == CS_FAST);
	assign expired   = tmr_sec >= limit_sec(state == CS_FAST,
		(state == CS_FAST) ? reg_tmr_cfg[1:0] : reg_tmr_cfg[7:6]);
	assign term_ok   = above_term_voltage && current_below_tenth;

	// Dropping input or enable is the only way out of safe or done
	always_comb begin
		next_state = state;
		if (!supply_ok)
			next_state = CS_IDLE;
		else
			case (state)
				CS_IDLE:
					if (!above_precharge_threshold)
						next_state = CS_PRE;
				CS_PRE:
					if (expired)
						next_state = CS_SAFE;
					else if (above_precharge_threshold)
						next_state = CS_FAST;
				CS_FAST:
					if (term_ok)
						next_state = CS_DONE;
					else if (expired)
						next_state = CS_SAFE;
				CS_SAFE: ;
				CS_DONE: ;
				default: next_state = CS_IDLE;
			endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			state <= CS_IDLE;
		else if (ce)
			state <= next_state;
	end

	// Expiry timer: cleared on entry to a phase, frozen at low current
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			tmr_sec <= 16'h0000;
		else if (ce) begin
			if (next_state != state)
				tmr_sec <= 16'h0000;
			else if (charging && sec_tick && !current_below_fifth && !expired)
				tmr_sec <= tmr_sec + 16'h0001;
		end
	end

	// Safe mode gives the tiny current only while the target margin is not met
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			charge_current_mode    <= CM_OFF;
			charge_target_voltage  <= 2'b00;
			charge_current_setting <= 4'h0;
		end else if (ce) begin
			charge_target_voltage  <= reg_chg_ctrl[6:5];
			charge_current_setting <= reg_chg_ctrl[3:0];
			case (state)
				CS_PRE:  charge_current_mode <= die_warn_level1 ? CM_MINIMUM : CM_PRE_TENTH;
				CS_FAST: charge_current_mode <= die_warn_level1 ? CM_MINIMUM : CM_PROGRAMMED;
				CS_SAFE: charge_current_mode <= above_term_voltage ? CM_OFF : CM_SAFE_TINY;
				default: charge_current_mode <= CM_OFF;
			endcase
		end
	end

	// Pulse when safe mode is left
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			safe_exit_irq <= 1'b0;
		else if (ce)
			safe_exit_irq <= (state == CS_SAFE) && (next_state != CS_SAFE);
		else
			safe_exit_irq <= 1'b0;
	end

	//==========================================================================
	// Battery presence and periodic detection
	//==========================================================================
	logic [3:0] det_sec;
	logic       det_en;

	assign det_en = reg_led_det[`BCC_DET_EN];

	// Presence is held while detection is disabled
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bat_present        <= 1'b0;
			battery_change_irq <= 1'b0;
		end else if (ce) begin
			battery_change_irq <= det_en && (battery_sense_cmp != bat_present);
			if (det_en)
				bat_present <= battery_sense_cmp;
		end else
			battery_change_irq <= 1'b0;
	end

	// Pulse once per detection period while an input is present
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			det_sec              <= 4'h0;
			battery_detect_pulse <= 1'b0;
		end else if (ce) begin
			battery_detect_pulse <= 1'b0;
			if (!input_present)
				det_sec <= 4'h0;
			else if (sec_tick) begin
				det_sec <= det_sec + 4'h1;
				if (det_sec == 4'(`BCC_DET_PERIOD_S - 1))
					battery_detect_pulse <= det_en;
			end
		end else
			battery_detect_pulse <= 1'b0;
	end

	//==========================================================================
	// Die temperature
	//==========================================================================
	// Status follows the comparator, which carries the hysteresis
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			die_ot           <= 1'b0;
			die_overtemp_irq <= 1'b0;
			shutdown_req     <= 1'b0;
		end else if (ce) begin
			die_ot           <= die_warn_level2;
			die_overtemp_irq <= die_warn_level2 && !die_ot && reg_irq_en[`BCC_OT_IRQ_EN];
			shutdown_req     <= die_warn_level3 && reg_shdn[`BCC_SHDN_EN];
		end else
			die_overtemp_irq <= 1'b0;
	end

	//==========================================================================
	// Indicator pin
	//==========================================================================
	logic next_led_low;
	logic alarm;

	assign alarm = (state == CS_SAFE) || die_warn_level2;

	// Overvoltage outranks other alarms, alarms outrank charge state
	always_comb begin
		next_led_low = 1'b0;
		if (!reg_led_det[`BCC_LED_SRC])
			case (reg_led_det[5:4])
				2'b01:   next_led_low = blink_low(2'b00, phase);
				2'b10:   next_led_low = blink_low(2'b10, phase);
				2'b11:   next_led_low = 1'b1;
				default: next_led_low = 1'b0;
			endcase
		else if (!reg_tmr_cfg[`BCC_LED_TYPE]) begin
			if (input_overvoltage)
				next_led_low = blink_low(2'b11, phase);
			else if (alarm)
				next_led_low = blink_low(2'b01, phase);
			else
				next_led_low = charging;
		end else begin
			if (!input_present)
				next_led_low = 1'b0;
			else if (input_overvoltage || alarm)
				next_led_low = blink_low(2'b11, phase);
			else if (charging)
				next_led_low = blink_low(2'b01, phase);
			else
				next_led_low = (state == CS_DONE);
		end
	end

	// Open drain: only ever pulls low
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			charge_indicator_pin_out <= 1'b0;
			charge_indicator_pin_oe  <= 1'b0;
		end else if (ce)
			charge_indicator_pin_oe <= next_led_low;
	end

	//==========================================================================
	// Checks
	//==========================================================================
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_start_charge: assert property (ce && state == CS_IDLE && supply_ok &&
		!above_precharge_threshold |=> state == CS_PRE)
		else $error("charge did not start");
	a_pre_current: assert property (ce && state == CS_PRE && !die_warn_level1
		|=> charge_current_mode == CM_PRE_TENTH)
		else $error("precharge current wrong");
	a_terminate: assert property (ce && state == CS_FAST && supply_ok && term_ok
		|=> state == CS_DONE)
		else $error("charge did not terminate");
	a_timer_hold: assert property (ce && current_below_fifth && next_state == state
		|=> tmr_sec == $past(tmr_sec))
		else $error("timer ran at low current");
	a_expiry_safe: assert property (ce && state == CS_PRE && supply_ok && expired
		|=> state == CS_SAFE ##1 !ce || charge_current_mode != CM_PRE_TENTH)
		else $error("expiry did not enter safe mode");
	a_safe_exit: assert property (ce && state == CS_SAFE && !supply_ok
		|=> safe_exit_irq && state == CS_IDLE ##1 !safe_exit_irq)
		else $error("safe exit not signalled");
	a_bat_change: assert property (ce && det_en && battery_sense_cmp != bat_present
		|=> battery_change_irq && bat_present == $past(battery_sense_cmp))
		else $error("presence change missed");
	a_min_current: assert property (ce && state == CS_FAST && die_warn_level1
		|=> charge_current_mode == CM_MINIMUM)
		else $error("minimum current not applied");
	a_ot_irq: assert property (ce && die_warn_level2 && !die_ot &&
		!reg_irq_en[`BCC_OT_IRQ_EN] |=> !die_overtemp_irq)
		else $error("masked over-temperature interrupt");
	a_shutdown: assert property (ce && die_warn_level3 && reg_shdn[`BCC_SHDN_EN]
		|=> shutdown_req)
		else $error("shutdown not requested");
	a_manual_low: assert property (ce && !reg_led_det[`BCC_LED_SRC] &&
		reg_led_det[5:4] == 2'b11 |=> charge_indicator_pin_oe)
		else $error("manual drive low failed");

	c_pre_to_fast: cover property (state == CS_PRE ##1 state == CS_FAST);
	c_full_charge: cover property (state == CS_FAST ##1 state == CS_DONE);
	c_safe_exit:   cover property (safe_exit_irq);
	c_det_pulse:   cover property (battery_detect_pulse);

endmodule // bcc_charger_ctrl

/* File: bcc_charger_ctrl_tb_top.sv */
// Self-checking testbench for the charger control block
`timescale 1ns/1ps
`include "bcc_consts.svh"

module bcc_charger_ctrl_tb_top import bcc_pkg::*;;
	//==========================================================================
	// Signals
	//==========================================================================
	typedef struct {
		logic [31:0] d;
		logic        e;
		logic        rd;
	} bcc_exp_t;

	logic          pclk, presetn, ce, psel, penable, pwrite;
	logic [9:0]    paddr;
	logic [31:0]   pwdata, prdata;
	logic          pready, pslverr;
	logic          input_present, input_overvoltage, above_precharge_threshold;
	logic          above_term_voltage, current_below_tenth, current_below_fifth;
	logic          battery_sense_cmp, die_warn_level1, die_warn_level2, die_warn_level3;
	bcc_cur_mode_t charge_current_mode;
	logic [1:0]    charge_target_voltage;
	logic [3:0]    charge_current_setting;
	logic          battery_detect_pulse, shutdown_req;
	logic          charge_indicator_pin_out, charge_indicator_pin_oe;
	logic          safe_exit_irq, battery_change_irq, die_overtemp_irq;
	bcc_exp_t      exp_q[$];
	bcc_exp_t      mon_e;
	int            error_cnt, samples_checked, safe_cnt, bat_cnt, ot_cnt, det_cnt;

	// One second is 16 clocks, so a 40 minute timer fits the run
	bcc_charger_ctrl #(.TICK_CYCLES(1)) bcc_charger_ctrl_i (.*);

	//==========================================================================
	// Clock, watchdog and event counters
	//==========================================================================
	initial pclk = 1'b0;
	always #50 pclk = ~pclk;

	// Longest test is the held expiry, about 45k cycles
	initial begin
		repeat (80000) @(posedge pclk);
		error_cnt++;
		$display("[ERR] %0t watchdog ran out", $time);
		summarize();
	end

	// Pulses are counted so a scenario can compare totals later
	always @(posedge pclk) begin
		safe_cnt += (safe_exit_irq === 1'b1);
		bat_cnt  += (battery_change_irq === 1'b1);
		ot_cnt   += (die_overtemp_irq === 1'b1);
		det_cnt  += (battery_detect_pulse === 1'b1);
	end

	// Completed transfers consume the oldest queued expectation
	always @(posedge pclk) begin
		if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
			if (exp_q.size() == 0) begin
				error_cnt++;
				$display("[ERR] %0t completion with nothing queued", $time);
			end else begin
				mon_e = exp_q.pop_front();
				cmp_bus(prdata, mon_e.d, pslverr, mon_e.e, mon_e.rd);
			end
		end
	end

	//==========================================================================
	// Compare and bus tasks
	//==========================================================================
	task automatic cmp_bus(input logic [31:0] g, x, input logic ge, xe, rd);
		samples_checked++;
		if ((rd && g !== x) || ge !== xe) begin
			error_cnt++;
			$display("[ERR] %0t bus got %h/%b want %h/%b", $time, g, ge, x, xe);
		end
	endtask

	task automatic cmp_int(input string what, input int g, x);
		samples_checked++;
		if (g != x) begin
			error_cnt++;
			$display("[ERR] %0t %s got %0d want %0d", $time, what, g, x);
		end
	endtask

	task automatic cmp_bit(input string what, input logic [3:0] g, x);
		samples_checked++;
		if (g !== x) begin
			error_cnt++;
			$display("[ERR] %0t %s got %h want %h", $time, what, g, x);
		end
	endtask

	task automatic cmp_mode(input bcc_cur_mode_t x);
		samples_checked++;
		if (charge_current_mode !== x) begin
			error_cnt++;
			$display("[ERR] %0t current mode %0d want %0d", $time, charge_current_mode, x);
		end
	endtask

	// Request held until pready is seen high at a rising edge
	task automatic apb(input logic [7:0] idx, input logic w, input logic [31:0] d, x,
			input logic xe);
		exp_q.push_back('{x, xe, !w});
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= {idx, 2'b00};
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] idx, input logic [31:0] d);
		apb(idx, 1'b1, d, 32'h0000_0000, 1'b0);
	endtask

	task automatic rd(input logic [7:0] idx, input logic [31:0] x);
		apb(idx, 1'b0, 32'h0000_0000, x, 1'b0);
	endtask

	// Bounded wait, the mode lags its cause by one or two edges
	task automatic wait_mode(input bcc_cur_mode_t m);
		int n;
		n = 0;
		while (charge_current_mode !== m && n < 40) begin
			@(posedge pclk);
			n++;
		end
		cmp_mode(m);
	endtask

	// Rises per 64 clocks equal four times the blink rate in Hz
	task automatic led(input int rises, highs);
		int   r, h;
		logic prev;
		r = 0;
		h = 0;
		repeat (3) @(posedge pclk);
		prev = charge_indicator_pin_oe;
		repeat (64) begin
			@(posedge pclk);
			h += (charge_indicator_pin_oe === 1'b1);
			r += (charge_indicator_pin_oe === 1'b1 && prev === 1'b0);
			prev = charge_indicator_pin_oe;
		end
		cmp_int("indicator rises", r, rises);
		cmp_int("indicator low time", h, highs);
	endtask

	task automatic summarize();
		$display("checks %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	//==========================================================================
	// Main sequence
	//==========================================================================
	initial begin
		int          n;
		logic [7:0]  rv, tv;
		int          rs[4];
		int          hs[4];
		rs = '{0, 2, 8, 0};
		hs = '{0, 16, 16, 64};
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{input_present, input_overvoltage, above_precharge_threshold} = '0;
		{above_term_voltage, current_below_tenth, current_below_fifth} = '0;
		{battery_sense_cmp, die_warn_level1, die_warn_level2, die_warn_level3} = '0;
		ce = 1'b1;
		void'($urandom(32'he996));
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		// Reset values, access kinds and an unmapped place
		rd(`BCC_IDX_LED_DET, 32'h0000_0040);
		rd(`BCC_IDX_CHG_CTRL, 32'h0000_00c8);
		rd(`BCC_IDX_TMR_CFG, 32'h0000_0041);
		rd(`BCC_IDX_IRQ_EN, 32'h0000_0000);
		rd(`BCC_IDX_SHDN, 32'h0000_0000);
		wr(`BCC_IDX_STATUS, 32'hffff_ffff);
		rd(`BCC_IDX_STATUS, 32'h0000_0000);
		apb(8'h02, 1'b1, 32'hffff_ffff, 32'h0000_0000, 1'b1);
		apb(8'h02, 1'b0, 32'h0000_0000, 32'h0000_0000, 1'b1);
		wr(`BCC_IDX_IRQ_EN, 32'hffff_ffff);
		rd(`BCC_IDX_IRQ_EN, 32'h0000_0080);
		wr(`BCC_IDX_IRQ_EN, 32'h0000_0000);
		// Random target, current and timer selections
		rv = 8'($urandom);
		wr(`BCC_IDX_CHG_CTRL, {24'h0, 1'b1, rv[6:5], 1'b0, rv[3:0]});
		rd(`BCC_IDX_CHG_CTRL, {24'h0, 1'b1, rv[6:5], 1'b0, rv[3:0]});
		cmp_bit("target", {2'b00, charge_target_voltage}, {2'b00, rv[6:5]});
		cmp_bit("current", charge_current_setting, rv[3:0]);
		tv = 8'($urandom);
		wr(`BCC_IDX_TMR_CFG, {24'h0, tv});
		rd(`BCC_IDX_TMR_CFG, {24'h0, tv & 8'hd3});
		// Every manual indicator pattern
		for (int p = 0; p < 4; p++) begin
			wr(`BCC_IDX_LED_DET, 32'h0000_0040 | (p << 4));
			led(rs[p], hs[p]);
		end
		// Start is refused while the battery sits above the threshold
		wr(`BCC_IDX_TMR_CFG, 32'h0000_0000);
		wr(`BCC_IDX_LED_DET, 32'h0000_0048);
		@(posedge pclk);
		battery_sense_cmp         <= 1'b1;
		above_precharge_threshold <= 1'b1;
		input_present             <= 1'b1;
		repeat (10) @(posedge pclk);
		cmp_mode(CM_OFF);
		led(0, 0);
		cmp_bit("indicator out", {3'b000, charge_indicator_pin_out}, 4'h0);
		input_present             <= 1'b0;
		above_precharge_threshold <= 1'b0;
		@(posedge pclk);
		input_present <= 1'b1;
		wait_mode(CM_PRE_TENTH);
		led(0, 64);
		@(posedge pclk);
		above_precharge_threshold <= 1'b1;
		wait_mode(CM_PROGRAMMED);
		die_warn_level1 <= 1'b1;
		wait_mode(CM_MINIMUM);
		die_warn_level1 <= 1'b0;
		wait_mode(CM_PROGRAMMED);
		input_overvoltage <= 1'b1;
		led(16, 16);
		input_overvoltage <= 1'b0;
		wr(`BCC_IDX_TMR_CFG, 32'h0000_0010);
		led(4, 16);
		// Die temperature alarm, gated interrupt and shutdown
		@(posedge pclk);
		die_warn_level2 <= 1'b1;
		led(16, 16);
		rd(`BCC_IDX_STATUS, 32'h0000_00a0);
		cmp_int("over-temp irq masked", ot_cnt, 0);
		die_warn_level2 <= 1'b0;
		wr(`BCC_IDX_IRQ_EN, 32'h0000_0080);
		@(posedge pclk);
		die_warn_level2 <= 1'b1;
		die_warn_level3 <= 1'b1;
		repeat (4) @(posedge pclk);
		cmp_int("over-temp irq", ot_cnt, 1);
		cmp_bit("shutdown masked", {3'b000, shutdown_req}, 4'h0);
		wr(`BCC_IDX_SHDN, 32'h0000_0004);
		repeat (3) @(posedge pclk);
		cmp_bit("shutdown", {3'b000, shutdown_req}, 4'h1);
		die_warn_level2 <= 1'b0;
		die_warn_level3 <= 1'b0;
		// Termination needs both voltage and low current
		above_term_voltage <= 1'b1;
		repeat (5) @(posedge pclk);
		cmp_mode(CM_PROGRAMMED);
		current_below_tenth <= 1'b1;
		ce                  <= 1'b0;
		// A frozen block must not terminate until the enable returns
		repeat (10) @(posedge pclk);
		cmp_mode(CM_PROGRAMMED);
		ce <= 1'b1;
		wait_mode(CM_OFF);
		led(0, 64);
		// Presence changes, with and without detection
		battery_sense_cmp <= 1'b0;
		rd(`BCC_IDX_STATUS, 32'h0000_0000);
		battery_sense_cmp <= 1'b1;
		repeat (3) @(posedge pclk);
		cmp_int("presence irqs", bat_cnt, 3);
		wr(`BCC_IDX_LED_DET, 32'h0000_0008);
		battery_sense_cmp <= 1'b0;
		repeat (4) @(posedge pclk);
		cmp_int("presence irqs disabled", bat_cnt, 3);
		battery_sense_cmp <= 1'b1;
		wr(`BCC_IDX_LED_DET, 32'h0000_0048);
		n = det_cnt;
		repeat (512) @(posedge pclk);
		cmp_int("detect pulses", det_cnt - n, 2);
		// Pre-charge expiry with a held stretch, then safe mode and exit
		input_present       <= 1'b0;
		above_term_voltage  <= 1'b0;
		current_below_tenth <= 1'b0;
		above_precharge_threshold <= 1'b0;
		wr(`BCC_IDX_TMR_CFG, 32'h0000_0000);
		input_present <= 1'b1;
		wait_mode(CM_PRE_TENTH);
		current_below_fifth <= 1'b1;
		repeat (6400) @(posedge pclk);
		current_below_fifth <= 1'b0;
		n = 6400;
		while (charge_current_mode !== CM_SAFE_TINY && n < 46000) begin
			@(posedge pclk);
			n++;
		end
		cmp_bit("expiry time", {3'b000, n > 44700 && n < 44900}, 4'h1);
		led(4, 16);
		rd(`BCC_IDX_STATUS, 32'h0000_0028);
		above_term_voltage <= 1'b1;
		wait_mode(CM_OFF);
		cmp_int("safe exit irq early", safe_cnt, 0);
		above_term_voltage <= 1'b0;
		wr(`BCC_IDX_CHG_CTRL, 32'h0000_0048);
		repeat (3) @(posedge pclk);
		cmp_int("safe exit irq", safe_cnt, 1);
		rd(`BCC_IDX_STATUS, 32'h0000_0020);
		wr(`BCC_IDX_CHG_CTRL, 32'h0000_00c8);
		wait_mode(CM_PRE_TENTH);
		summarize();
	end
endmodule // bcc_charger_ctrl_tb_top
